// ### verilog/tgc_pkg.sv
package tgc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] TGC_IDX_WORD_ZERO = 8'h01;
    localparam logic [7:0] TGC_IDX_WORD_LAST = 8'hA0;
    localparam logic [7:0] TGC_IDX_P1_INDEX = 8'hA8;
    localparam logic [7:0] TGC_IDX_P1_START_TIME = 8'hA9;
    localparam logic [7:0] TGC_IDX_P1_HOLD_TIME = 8'hAA;
    localparam logic [7:0] TGC_IDX_P2_GAIN = 8'hAB;
    localparam logic [7:0] TGC_IDX_P2_STEPS = 8'hAC;
    localparam logic [7:0] TGC_IDX_P2_INDEX = 8'hAD;
    localparam logic [7:0] TGC_IDX_P2_START_TIME = 8'hAE;
    localparam logic [7:0] TGC_IDX_P2_HOLD_TIME = 8'hAF;
    localparam logic [7:0] TGC_IDX_P3_GAIN = 8'hB0;
    localparam logic [7:0] TGC_IDX_P3_STEPS = 8'hB1;
    localparam logic [7:0] TGC_IDX_P3_INDEX = 8'hB2;
    localparam logic [7:0] TGC_IDX_P3_START_TIME = 8'hB3;
    localparam logic [7:0] TGC_IDX_P3_HOLD_TIME = 8'hB4;
    localparam logic [7:0] TGC_IDX_MANUAL = 8'hB5;
    localparam logic [7:0] TGC_IDX_MODE = 8'hB6;
    localparam logic [7:0] TGC_IDX_WAIT = 8'hB7;
    localparam logic [7:0] TGC_IDX_ATTEN_A = 8'hB9;
    localparam logic [7:0] TGC_IDX_ATTEN_B = 8'hBA;
    // Control register holding the write enable
    localparam logic [7:0] TGC_IDX_CTRL = 8'hC0;
    localparam int TGC_CTRL_WREN_BIT = 0;

    localparam int TGC_MEM_DEPTH = 160;
    localparam int TGC_PARAM_COUNT = 19;
    localparam int TGC_WORD_W = 16;
    localparam int TGC_ADDR_W = 10;

    localparam logic [15:0] TGC_PARAM_RESET = 16'h0000;
    localparam logic [31:0] TGC_UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [TGC_ADDR_W-1:0] adr;
        logic [31:0] dat;
    } tgc_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } tgc_wb_rsp_type;

    typedef enum logic [1:0] {
        TGC_REG_NONE = 2'b00,
        TGC_REG_MEM = 2'b01,
        TGC_REG_PARAM = 2'b10,
        TGC_REG_CTRL = 2'b11
    } tgc_region_type;

    function automatic logic [7:0] tgc_index(input logic [TGC_ADDR_W-1:0] adr);
        return adr[TGC_ADDR_W-1:2];
    endfunction

    // Parameter slot 0..17 for indices A8..B7, B9, BA; 5'h1F when none
    function automatic logic [4:0] tgc_param_slot(input logic [7:0] idx);
        logic [4:0] slot;
        slot = 5'h1F;
        if (idx >= TGC_IDX_P1_INDEX && idx <= TGC_IDX_WAIT) begin
            slot = 5'(idx - TGC_IDX_P1_INDEX);
        end else if (idx == TGC_IDX_ATTEN_A || idx == TGC_IDX_ATTEN_B) begin
            slot = 5'(idx - TGC_IDX_P1_INDEX - 8'h01);
        end
        return slot;
    endfunction

endpackage

// ### verilog/tgc_step_mem.sv
`timescale 1ns/1ns
module tgc_step_mem
    import tgc_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [TGC_WORD_W-1:0] wr_data_i,
    input wire logic [1:0] wr_lane_i,
    // Read port
    input wire logic [7:0] rd_addr_i,
    output logic [TGC_WORD_W-1:0] rd_data_o
);
    import tgc_pkg::*;

    // No reset on purpose: contents survive any reset
    logic [TGC_WORD_W-1:0] words_ff [TGC_MEM_DEPTH];

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i && wr_lane_i[0]) begin
            words_ff[wr_addr_i][7:0] <= wr_data_i[7:0];
        end
        if (wr_en_i && wr_lane_i[1]) begin
            words_ff[wr_addr_i][15:8] <= wr_data_i[15:8];
        end
    end

    assign rd_data_o = words_ff[rd_addr_i];

endmodule

// ### verilog/tgc_regbank.sv
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
module tgc_regbank
    import tgc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Wishbone slave
    input wire tgc_pkg::tgc_wb_req_type wb_req_i,
    output tgc_pkg::tgc_wb_rsp_type wb_rsp_o,
    // Gain engine side
    input wire logic [7:0] step_rd_addr_i,
    output logic [TGC_WORD_W-1:0] step_rd_data_o,
    output logic [TGC_PARAM_COUNT*TGC_WORD_W-1:0] params_o,
    output logic map_wr_enable_o
);
    import tgc_pkg::*;

    logic ack_ff;
    logic [31:0] rdata_ff;
    logic wren_ff;
    logic [TGC_WORD_W-1:0] param_ff [TGC_PARAM_COUNT];

    wire logic [7:0] idx = tgc_index(wb_req_i.adr);
    wire logic [4:0] slot = tgc_param_slot(idx);
    wire logic req = wb_req_i.cyc && wb_req_i.stb && !ack_ff;
    wire logic wr = req && wb_req_i.we;
    wire logic [1:0] lanes = wb_req_i.sel[1:0];

    tgc_region_type region;
    assign region = (idx >= TGC_IDX_WORD_ZERO && idx <= TGC_IDX_WORD_LAST) ? TGC_REG_MEM :
                    (slot != 5'h1F) ? TGC_REG_PARAM :
                    (idx == TGC_IDX_CTRL) ? TGC_REG_CTRL : TGC_REG_NONE;

    // Control bit is never gated, else the map could never be unlocked
    wire logic map_wr = wr && wren_ff;
    wire logic mem_wr = map_wr && region == TGC_REG_MEM;
    wire logic par_wr = map_wr && region == TGC_REG_PARAM;
    wire logic ctl_wr = wr && region == TGC_REG_CTRL && wb_req_i.sel[0];
    wire logic [7:0] mem_addr = 8'(idx - TGC_IDX_WORD_ZERO);
    wire logic [7:0] rd_mux_addr = req ? mem_addr : step_rd_addr_i;

    logic [TGC_WORD_W-1:0] mem_rdata;

    tgc_step_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(mem_addr),
        .wr_data_i(wb_req_i.dat[15:0]),
        .wr_lane_i(lanes),
        .rd_addr_i(rd_mux_addr),
        .rd_data_o(mem_rdata)
    );

    wire logic [31:0] rd_value =
        (region == TGC_REG_MEM) ? {16'h0000, mem_rdata} :
        (region == TGC_REG_PARAM) ? {16'h0000, param_ff[slot]} :
        (region == TGC_REG_CTRL) ? {31'h0000_0000, wren_ff} : TGC_UNMAPPED_DATA;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            wren_ff <= 1'b0;
        end else begin
            ack_ff <= req;
            rdata_ff <= req ? rd_value : rdata_ff;
            if (ctl_wr) begin
                wren_ff <= wb_req_i.dat[TGC_CTRL_WREN_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < TGC_PARAM_COUNT; i++) begin
                param_ff[i] <= TGC_PARAM_RESET;
            end
        end else if (par_wr) begin
            if (lanes[0]) begin
                param_ff[slot][7:0] <= wb_req_i.dat[7:0];
            end
            if (lanes[1]) begin
                param_ff[slot][15:8] <= wb_req_i.dat[15:8];
            end
        end
    end

    // Engine read port loses the memory for the single cycle of a bus access
    assign step_rd_data_o = mem_rdata;
    assign map_wr_enable_o = wren_ff;
    assign wb_rsp_o.ack = ack_ff;
    assign wb_rsp_o.dat = rdata_ff;

    genvar g;
    generate
        for (g = 0; g < TGC_PARAM_COUNT; g++) begin : g_par
            assign params_o[g*TGC_WORD_W +: TGC_WORD_W] = param_ff[g];
        end
    endgenerate

    // Tracks whether word zero holds a written value; no reset, like the word itself
    logic word0_known_ff;

    always_ff @(posedge clk_sys_i) begin
        word0_known_ff <= word0_known_ff | (mem_wr && mem_addr == 8'h00 && lanes == 2'b11);
    end

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_locked_mem_write;
        req && wb_req_i.we && !wren_ff && region == TGC_REG_MEM && lanes == 2'b11;
    endsequence

    sequence s_open_mem_write;
        req && wb_req_i.we && wren_ff && region == TGC_REG_MEM && lanes == 2'b11;
    endsequence

    sequence s_open_par_write;
        req && wb_req_i.we && wren_ff && region == TGC_REG_PARAM && lanes == 2'b11;
    endsequence

    sequence s_locked_par_write;
        req && wb_req_i.we && !wren_ff && region == TGC_REG_PARAM;
    endsequence

    sequence s_bus_read;
        req && !wb_req_i.we;
    endsequence

    sequence s_ctl_write;
        ctl_wr;
    endsequence

    sequence s_ack_then_idle;
        wb_rsp_o.ack ##1 !wb_rsp_o.ack;
    endsequence

    locked_mem_hold_a: assert property (
        s_locked_mem_write |=> u_mem.words_ff[$past(mem_addr)] == $past(mem_rdata))
        else $error("locked write changed a gain-step word");

    open_mem_store_a: assert property (
        s_open_mem_write |=> u_mem.words_ff[$past(mem_addr)] == $past(wb_req_i.dat[15:0]))
        else $error("enabled write not stored in gain-step word");

    locked_par_hold_a: assert property (
        (req && wb_req_i.we && !wren_ff && region == TGC_REG_PARAM)
            |=> $stable(params_o))
        else $error("locked write changed a parameter register");

    mem_readback_a: assert property (
        (req && !wb_req_i.we && region == TGC_REG_MEM)
            |=> wb_rsp_o.ack && wb_rsp_o.dat == {16'h0000, $past(mem_rdata)})
        else $error("gain-step read data wrong");

    last_word_decode_a: assert property (
        (req && idx == TGC_IDX_WORD_LAST) |-> region == TGC_REG_MEM && mem_addr == 8'h9F)
        else $error("last gain-step word decoded wrongly");

    mem_reset_free_a: assert property (
        (word0_known_ff && !(mem_wr && mem_addr == 8'h00))
            |=> $stable(u_mem.words_ff[0]))
        else $error("gain-step word zero changed without a write");

    ack_one_cycle_a: assert property (
        ack_ff |=> !ack_ff)
        else $error("ack held longer than one cycle");

    unmapped_zero_a: assert property (
        (req && region == TGC_REG_NONE) |=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Checked through reset itself, so the default disable is overridden
    step_reset_keep_a: assert property (disable iff (1'b0)
        (word0_known_ff && !rst_b_i)
            |=> $stable(u_mem.words_ff[0]))
        else $error("reset changed gain-step word zero");

    par_store_a: assert property (
        s_open_par_write
            |=> param_ff[$past(slot)] == $past(wb_req_i.dat[15:0]))
        else $error("enabled write not stored in parameter register");

    locked_par_keep_a: assert property (
        s_locked_par_write
            |=> param_ff[$past(slot)] == $past(param_ff[slot]))
        else $error("locked write altered its parameter register");

    ctl_store_a: assert property (
        s_ctl_write
            |=> wren_ff == $past(wb_req_i.dat[TGC_CTRL_WREN_BIT]))
        else $error("write enable bit not stored");

    ctl_hold_a: assert property (
        !ctl_wr
            |=> $stable(wren_ff))
        else $error("write enable bit changed without a write");

    first_word_decode_a: assert property (
        (req && idx == TGC_IDX_WORD_ZERO)
            |-> region == TGC_REG_MEM && mem_addr == 8'h00)
        else $error("gain-step word zero decoded wrongly");

    below_map_a: assert property (
        (req && idx == 8'h00)
            |-> region == TGC_REG_NONE)
        else $error("index zero decoded as a register");

    hole_decode_a: assert property (
        (req && idx == 8'hB8)
            |-> region == TGC_REG_NONE)
        else $error("unused parameter index decoded");

    ack_answer_a: assert property (
        req
            |=> wb_rsp_o.ack)
        else $error("taken request not acknowledged");

    ack_idle_a: assert property (
        !req
            |=> !wb_rsp_o.ack)
        else $error("ack without a request");

    ack_pulse_a: assert property (
        req
            |=> s_ack_then_idle)
        else $error("ack not a single pulse");

    read_keeps_par_a: assert property (
        s_bus_read
            |=> $stable(params_o))
        else $error("read altered a parameter register");

    read_keeps_enable_a: assert property (
        s_bus_read
            |=> $stable(wren_ff))
        else $error("read altered the write enable bit");

    rdata_stand_a: assert property (
        !req
            |=> $stable(wb_rsp_o.dat))
        else $error("read data changed without a request");

    par_readback_a: assert property (
        (req && !wb_req_i.we && region == TGC_REG_PARAM)
            |=> wb_rsp_o.dat == {16'h0000, $past(param_ff[slot])})
        else $error("parameter read data wrong");

    ctl_readback_a: assert property (
        (req && !wb_req_i.we && region == TGC_REG_CTRL)
            |=> wb_rsp_o.dat == {31'h00000000, $past(wren_ff)})
        else $error("write enable read data wrong");

    slot_range_a: assert property (
        (region == TGC_REG_PARAM)
            |-> slot <= 5'h11)
        else $error("parameter slot out of range");

    mem_range_a: assert property (
        (region == TGC_REG_MEM)
            |-> mem_addr <= 8'h9F)
        else $error("gain-step address out of range");

    locked_no_mem_a: assert property (
        !wren_ff
            |-> !mem_wr)
        else $error("gain-step write while locked");

    unused_slot_a: assert property (
        1'b1
            |-> params_o[TGC_PARAM_COUNT*TGC_WORD_W-1 -: TGC_WORD_W] == TGC_PARAM_RESET)
        else $error("unused parameter slot not zero");

    engine_port_a: assert property (
        !req
            |-> rd_mux_addr == step_rd_addr_i)
        else $error("engine read index not routed");

    bus_port_a: assert property (
        req
            |-> rd_mux_addr == mem_addr)
        else $error("bus read index not routed");

    open_write_ack_a: assert property (
        s_open_par_write
            |=> wb_rsp_o.ack)
        else $error("enabled write not acknowledged");

    locked_write_ack_a: assert property (
        s_locked_par_write
            |=> wb_rsp_o.ack)
        else $error("locked parameter write not acknowledged");

    locked_mem_ack_a: assert property (
        s_locked_mem_write
            |=> wb_rsp_o.ack)
        else $error("locked gain-step write not acknowledged");

    upper_half_zero_a: assert property (
        wb_rsp_o.ack
            |-> wb_rsp_o.dat[31:16] == 16'h0000)
        else $error("upper read half not zero");

endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    import tgc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    tgc_wb_req_type req = '0;
    tgc_wb_rsp_type rsp;
    logic [7:0] rd_idx = 8'h00;
    logic [TGC_WORD_W-1:0] step_q;
    logic [TGC_PARAM_COUNT*TGC_WORD_W-1:0] params;
    logic wr_en_q;
    logic [15:0] mem [TGC_MEM_DEPTH];
    logic [15:0] pval;
    int sl;
    logic [31:0] exp_q [$];
    int err_total = 0;
    int checks_done = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    tgc_regbank dut (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .wb_req_i(req),
        .wb_rsp_o(rsp),
        .step_rd_addr_i(rd_idx),
        .step_rd_data_o(step_q),
        .params_o(params),
        .map_wr_enable_o(wr_en_q)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Held until ack is sampled; upper half of dat is junk that must be dropped
    task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: {idx, 2'b00}, dat: {~d, d}};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        if (rsp.ack !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        exp_q.push_back({16'h0000, exp});
        wb(1'b0, idx, 16'h0000);
    endtask

    // Read data is judged at the edge that samples ack
    always @(posedge clk_sys_i) begin
        if (rsp.ack === 1'b1 && req.cyc === 1'b1 && req.we === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 32'h1, 32'h0);
            end else begin
                chk("read data", rsp.dat, exp_q.pop_front());
            end
        end
    end

    initial begin
        void'($urandom(41088));
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        chk("enable at reset", {31'h0, wr_en_q}, 32'h0);
        wb(1'b1, TGC_IDX_P1_INDEX, 16'hA5A5);
        rd(TGC_IDX_P1_INDEX, TGC_PARAM_RESET);
        wb(1'b1, TGC_IDX_CTRL, 16'h0001);
        rd(TGC_IDX_CTRL, 16'h0001);
        for (int i = 0; i < TGC_MEM_DEPTH; i++) begin
            mem[i] = 16'($urandom);
            wb(1'b1, 8'(i + 1), mem[i]);
        end
        // Parameter block including the hole at B8
        for (int k = 8'hA8; k <= 8'hBA; k++) begin
            pval = 16'($urandom);
            wb(1'b1, 8'(k), pval);
            rd(8'(k), (k == 8'hB8) ? 16'h0000 : pval);
            sl = (k < 8'hB9) ? k - 8'hA8 : k - 8'hA9;
            if (k != 8'hB8) begin
                chk("param port", 32'(params[sl*16 +: 16]), 32'(pval));
            end
        end
        rd(8'h00, 16'h0000);
        // Reset in mid-run must spare the step words
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(TGC_IDX_CTRL, 16'h0000);
        rd(TGC_IDX_P3_HOLD_TIME, TGC_PARAM_RESET);
        wb(1'b1, TGC_IDX_WORD_ZERO, ~mem[0]);
        wb(1'b1, TGC_IDX_WORD_LAST, ~mem[TGC_MEM_DEPTH-1]);
        for (int i = 0; i < TGC_MEM_DEPTH; i++) begin
            rd(8'(i + 1), mem[i]);
        end
        for (int i = 0; i < TGC_MEM_DEPTH; i += 53) begin
            @(posedge clk_sys_i);
            rd_idx <= 8'(i);
            @(negedge clk_sys_i);
            chk("engine read", {16'h0000, step_q}, {16'h0000, mem[i]});
        end
        repeat (3) @(posedge clk_sys_i);
        wrap_up();
    end
endmodule
